// ### dpc_pkg.sv
// ==========================================================
// shared constants and types
package dpc_pkg;
  // register byte addresses
  localparam logic [7:0] ADDR_GEAR_NUM = 8'h00;
  localparam logic [7:0] ADDR_GEAR_DEN = 8'h04;
  localparam logic [7:0] ADDR_CFG = 8'h08;
  localparam logic [7:0] ADDR_TGT_LO = 8'h0c;
  localparam logic [7:0] ADDR_TGT_HI = 8'h10;
  localparam logic [7:0] ADDR_HOLD = 8'h14;
  localparam logic [7:0] ADDR_MODE = 8'h18;
  localparam logic [7:0] ADDR_STATUS = 8'h1c;
  localparam logic [7:0] ADDR_IRQ_STS = 8'h20;
  localparam logic [7:0] ADDR_IRQ_MASK = 8'h24;
  localparam logic [7:0] ADDR_POSITION = 8'h28;
  // reset values
  localparam logic [15:0] RST_GEAR = 16'h03e8;
  localparam logic [15:0] RST_CFG = 16'h0000;
  localparam logic [15:0] RST_MODE = 16'h0000;
  localparam logic [15:0] RST_HOLD = 16'h0000;
  // control mode meaning position control, digital source
  localparam logic [15:0] MODE_DIGITAL_POS = 16'h0011;
  // positioning_config bit positions
  localparam int CFG_ABS = 0;
  localparam int CFG_AUTO = 1;
  localparam int CFG_RECIP = 2;
  localparam int CFG_POSTYPE = 3;
  localparam int CFG_DONE_LEVEL = 6;
  localparam int CFG_FIRST_RUN = 7;
  localparam int CFG_EN_LEVEL = 8;
  // interrupt status bits
  localparam int IRQ_DONE = 0;
  localparam int IRQ_UNSUP = 1;
  localparam int IRQ_W = 2;
  // completion hold time unit
  localparam int CLK_PERIOD_NS = 100;
  localparam int HOLD_UNIT_NS = 1000000;
  localparam int HOLD_UNIT_CYCLES = HOLD_UNIT_NS / CLK_PERIOD_NS;
  // sequencer states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b00,
    ST_WAIT = 2'b01,
    ST_CALC = 2'b10,
    ST_MOVE = 2'b11
  } dpc_state_t;
  // command handed to the position loop
  typedef struct packed {
    logic [31:0] target;
    logic back;
  } dpc_move_t;
endpackage : dpc_pkg

// ### dpc_sync.sv
`timescale 1ns/1ns
// ==========================================================
// two-flop synchroniser with rising-edge detect
module dpc_sync (
  input wire logic clk,
  input wire logic rstn,
  input wire logic din,
  output logic lvl,
  output logic rise
);
  logic s1_reg;
  logic s2_reg;
  logic s3_reg;
  // first flop feeds only the second
  always_ff @(posedge clk) begin
    if (!rstn) begin
      s1_reg <= 1'b0;
      s2_reg <= 1'b0;
      s3_reg <= 1'b0;
    end else begin
      s1_reg <= din;
      s2_reg <= s1_reg;
      s3_reg <= s2_reg;
    end
  end
  assign lvl = s2_reg;
  assign rise = s2_reg & ~s3_reg;
endmodule : dpc_sync

// ### dpc_divider.sv
`timescale 1ns/1ns
// ==========================================================
// restoring unsigned divider, one quotient bit per cycle
module dpc_divider #(
  parameter int NW = 48,
  parameter int DW = 16
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic start,
  input wire logic [NW-1:0] dividend,
  input wire logic [DW-1:0] divisor,
  output logic [NW-1:0] quotient,
  output logic valid
);
  localparam int CW = $clog2(NW + 1);
  initial begin
    if (NW < 2 || DW < 1 || DW > NW) $error("dpc_divider: bad widths");
  end
  logic [DW:0] rem_reg;
  logic [DW-1:0] dvs_reg;
  logic [CW-1:0] cnt_reg;
  logic busy_reg;
  wire [DW:0] rem_sh = {rem_reg[DW-1:0], quotient[NW-1]};
  wire ge = rem_sh >= {1'b0, dvs_reg};
  // shift-subtract loop
  always_ff @(posedge clk) begin
    if (!rstn) begin
      rem_reg <= '0;
      dvs_reg <= '0;
      cnt_reg <= '0;
      busy_reg <= 1'b0;
      quotient <= '0;
      valid <= 1'b0;
    end else if (start) begin
      rem_reg <= '0;
      dvs_reg <= divisor;
      cnt_reg <= CW'(NW);
      busy_reg <= 1'b1;
      quotient <= dividend;
      valid <= 1'b0;
    end else if (busy_reg) begin
      rem_reg <= ge ? rem_sh - {1'b0, dvs_reg} : rem_sh;
      quotient <= {quotient[NW-2:0], ge};
      cnt_reg <= cnt_reg - CW'(1);
      busy_reg <= cnt_reg != CW'(1);
      valid <= cnt_reg == CW'(1);
    end else begin
      valid <= 1'b0;
    end
  end
endmodule : dpc_divider

// ### dpc_top.sv
// The implementer's own choices: the placing of the registers and register access over APB.
`timescale 1ns/1ns
// Notes on behaviour
// - each position command is scaled by numerator over denominator, both 1..65535, reset 1000.
// - config bit 0 low means relative displacement, high means absolute position.
// - config bit 1 low starts cycles from the enable terminal, high repeats automatically.
// - terminal-started cycling is always continuous, never reciprocating.
// - config bit 2 selects continuous or reciprocating, the latter only in automatic cycling.
// - in position type any write to a target word starts a move to the new position.
// - position type together with continuous cycling is unsupported and makes no move.
// - config bit 6 low pulses completion for the hold time, high holds it while complete.
// - config bit 7 high makes the first move as soon as the run command arrives.
// - config bit 7 low delays the first move until enable terminal or automatic cycling.
// - config bits 4 and 5 are reserved and ignored.
// - positioning acts only while the control mode holds 0x0011.
// - config bit 8 low acts on an enable edge, high on the enable level.
module dpc_top #(
  parameter int HOLD_TICK_CYCLES = dpc_pkg::HOLD_UNIT_CYCLES
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic run_pin,
  input wire logic pos_enable_pin,
  input wire logic move_done_pin,
  output dpc_pkg::dpc_move_t move_cmd,
  output logic move_req,
  output logic pos_complete,
  output logic irq
);
  import dpc_pkg::*;
  initial begin
    if (HOLD_TICK_CYCLES < 1) $error("dpc_top: tick must be at least one cycle");
  end

  // ==========================================================
  // pin synchronisers
  logic run_lvl, en_lvl, en_rise, done_rise;
  dpc_sync u_run (.clk(mclk), .rstn(rstn), .din(run_pin), .lvl(run_lvl), .rise());
  dpc_sync u_en (.clk(mclk), .rstn(rstn), .din(pos_enable_pin), .lvl(en_lvl),
    .rise(en_rise));
  dpc_sync u_done (.clk(mclk), .rstn(rstn), .din(move_done_pin), .lvl(),
    .rise(done_rise));

  // ==========================================================
  // registers
  logic [15:0] gear_ratio_numerator_reg, gear_ratio_denominator_reg;
  logic [15:0] positioning_config_reg, target_low_word_reg, target_high_word_reg;
  logic [15:0] completion_hold_time_reg, control_mode_select_reg;
  logic [IRQ_W-1:0] irq_sts_reg, irq_mask_reg;
  logic [31:0] position_reg, origin_reg;
  logic [15:0] hold_cnt_reg;
  logic [31:0] tick_cnt_reg;
  dpc_state_t state_reg;
  logic first_reg, back_reg, tgt_wr_reg, stale_reg, sign_reg;

  // apb decode
  wire setup = psel & ~penable;
  wire acc = psel & penable & pready;
  wire wr = acc & pwrite;
  wire wr_num = wr && paddr == ADDR_GEAR_NUM;
  wire wr_den = wr && paddr == ADDR_GEAR_DEN;
  wire wr_cfg = wr && paddr == ADDR_CFG;
  wire wr_lo = wr && paddr == ADDR_TGT_LO;
  wire wr_hi = wr && paddr == ADDR_TGT_HI;
  wire wr_hold = wr && paddr == ADDR_HOLD;
  wire wr_mode = wr && paddr == ADDR_MODE;
  wire wr_sts = wr && paddr == ADDR_IRQ_STS;
  wire wr_mask = wr && paddr == ADDR_IRQ_MASK;
  wire mapped = paddr <= ADDR_POSITION && paddr[1:0] == 2'b00;

  // configuration decode, bits 4 and 5 never read
  wire [15:0] cfg = positioning_config_reg;
  wire cfg_abs = cfg[CFG_ABS];
  wire cfg_auto = cfg[CFG_AUTO];
  wire cfg_recip = cfg[CFG_RECIP] & cfg_auto;
  wire cfg_postype = cfg[CFG_POSTYPE];
  wire active = control_mode_select_reg == MODE_DIGITAL_POS;
  wire unsup = cfg_postype & ~cfg_recip;

  // trigger selection
  wire first_go = first_reg & cfg[CFG_FIRST_RUN];
  wire en_go = cfg[CFG_EN_LEVEL] ? en_lvl : en_rise;
  wire cyc_go = cfg_auto | en_go;
  wire pos_go = cfg_postype & tgt_wr_reg;
  wire trig = first_go | cyc_go | pos_go;
  wire in_wait = state_reg == ST_WAIT;
  wire launch = in_wait & run_lvl & active & trig & ~unsup;
  wire refuse = in_wait & run_lvl & active & trig & unsup;

  // ==========================================================
  // gear scaling of the signed target
  wire [31:0] target = {target_high_word_reg, target_low_word_reg};
  wire [31:0] mag = target[31] ? 32'h0 - target : target;
  wire [47:0] product = mag * gear_ratio_numerator_reg;
  wire [47:0] quotient;
  wire div_valid;
  dpc_divider #(.NW(48), .DW(16)) u_div (
    .clk(mclk),
    .rstn(rstn),
    .start(launch),
    .dividend(product),
    .divisor(gear_ratio_denominator_reg),
    .quotient(quotient),
    .valid(div_valid)
  );
  wire [31:0] scaled = sign_reg ? 32'h0 - quotient[31:0] : quotient[31:0];

  // destination: back stroke returns, forward stroke goes out
  wire [31:0] fwd_dest = cfg_abs ? scaled : position_reg + scaled;
  wire [31:0] back_dest = cfg_abs ? origin_reg : position_reg - scaled;
  wire [31:0] dest = back_reg ? back_dest : fwd_dest;

  // ==========================================================
  // apb register writes; zero gear values are refused
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      gear_ratio_numerator_reg <= RST_GEAR;
      gear_ratio_denominator_reg <= RST_GEAR;
      positioning_config_reg <= RST_CFG;
      target_low_word_reg <= '0;
      target_high_word_reg <= '0;
      completion_hold_time_reg <= RST_HOLD;
      control_mode_select_reg <= RST_MODE;
      irq_mask_reg <= '0;
    end else begin
      if (wr_num && pwdata[15:0] != 16'h0) gear_ratio_numerator_reg <= pwdata[15:0];
      if (wr_den && pwdata[15:0] != 16'h0) gear_ratio_denominator_reg <= pwdata[15:0];
      if (wr_cfg) positioning_config_reg <= pwdata[15:0];
      if (wr_lo) target_low_word_reg <= pwdata[15:0];
      if (wr_hi) target_high_word_reg <= pwdata[15:0];
      if (wr_hold) completion_hold_time_reg <= pwdata[15:0];
      if (wr_mode) control_mode_select_reg <= pwdata[15:0];
      if (wr_mask) irq_mask_reg <= pwdata[IRQ_W-1:0];
    end
  end

  // apb answer: no wait states, registered data
  wire [31:0] status_word = {24'h0, state_reg, back_reg, stale_reg, unsup, pos_complete,
    first_reg, active};
  logic [31:0] rdata;
  always_comb begin
    unique case (paddr)
      ADDR_GEAR_NUM: rdata = {16'h0, gear_ratio_numerator_reg};
      ADDR_GEAR_DEN: rdata = {16'h0, gear_ratio_denominator_reg};
      ADDR_CFG: rdata = {16'h0, positioning_config_reg};
      ADDR_TGT_LO: rdata = {16'h0, target_low_word_reg};
      ADDR_TGT_HI: rdata = {16'h0, target_high_word_reg};
      ADDR_HOLD: rdata = {16'h0, completion_hold_time_reg};
      ADDR_MODE: rdata = {16'h0, control_mode_select_reg};
      ADDR_STATUS: rdata = status_word;
      ADDR_IRQ_STS: rdata = {30'h0, irq_sts_reg};
      ADDR_IRQ_MASK: rdata = {30'h0, irq_mask_reg};
      ADDR_POSITION: rdata = position_reg;
      default: rdata = 32'h0;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      pready <= 1'b0;
      prdata <= '0;
      pslverr <= 1'b0;
    end else begin
      pready <= setup;
      prdata <= setup && !pwrite ? rdata : 32'h0;
      pslverr <= setup & ~mapped;
    end
  end

  // ==========================================================
  // interrupt status, set wins over write-one-clear
  wire [IRQ_W-1:0] irq_set = {refuse, done_rise & (state_reg == ST_MOVE)};
  wire [IRQ_W-1:0] irq_clr = wr_sts ? pwdata[IRQ_W-1:0] : '0;
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      irq_sts_reg <= '0;
      irq <= 1'b0;
    end else begin
      irq_sts_reg <= (irq_sts_reg & ~irq_clr) | irq_set;
      irq <= |(((irq_sts_reg & ~irq_clr) | irq_set) & irq_mask_reg);
    end
  end

  // ==========================================================
  // positioning sequencer
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      state_reg <= ST_IDLE;
      first_reg <= 1'b0;
      back_reg <= 1'b0;
      sign_reg <= 1'b0;
      position_reg <= '0;
      origin_reg <= '0;
      move_cmd <= '0;
      move_req <= 1'b0;
    end else begin
      move_req <= 1'b0;
      if (!run_lvl || !active) begin
        state_reg <= ST_IDLE;
        back_reg <= 1'b0;
      end else begin
        unique case (state_reg)
          ST_IDLE: begin
            first_reg <= 1'b1;
            state_reg <= ST_WAIT;
          end
          ST_WAIT: if (launch) begin
            sign_reg <= target[31];
            state_reg <= ST_CALC;
          end
          ST_CALC: if (div_valid) begin
            move_cmd <= '{target: dest, back: back_reg};
            move_req <= 1'b1;
            if (!back_reg) origin_reg <= position_reg;
            state_reg <= ST_MOVE;
          end
          ST_MOVE: if (done_rise) begin
            position_reg <= move_cmd.target;
            back_reg <= cfg_recip & ~back_reg;
            first_reg <= 1'b0;
            state_reg <= ST_WAIT;
          end
        endcase
      end
    end
  end

  // target write tracking: a write arms position type, a launch consumes it
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      tgt_wr_reg <= 1'b0;
      stale_reg <= 1'b0;
    end else begin
      tgt_wr_reg <= (wr_lo | wr_hi) | (tgt_wr_reg & ~launch);
      stale_reg <= ~(wr_lo | wr_hi) & (stale_reg | (launch & ~cfg_postype));
    end
  end

  // ==========================================================
  // completion output with hold-time tick divider
  wire tick = tick_cnt_reg == 32'(HOLD_TICK_CYCLES - 1);
  always_ff @(posedge mclk) begin
    if (!rstn) begin
      tick_cnt_reg <= '0;
      hold_cnt_reg <= '0;
      pos_complete <= 1'b0;
    end else begin
      tick_cnt_reg <= tick ? 32'h0 : tick_cnt_reg + 32'h1;
      if (state_reg == ST_MOVE && done_rise) begin
        pos_complete <= 1'b1;
        hold_cnt_reg <= completion_hold_time_reg;
        tick_cnt_reg <= '0;
      end else if (move_req || !run_lvl) begin
        pos_complete <= 1'b0;
      end else if (!cfg[CFG_DONE_LEVEL]) begin
        // drop on the tick that ends the last hold unit
        if (hold_cnt_reg == 16'h0 || (tick && hold_cnt_reg == 16'h1)) pos_complete <= 1'b0;
        if (tick && hold_cnt_reg != 16'h0) hold_cnt_reg <= hold_cnt_reg - 16'h1;
      end
    end
  end

  // ==========================================================
  // checks
  sequence s_go;
    move_req ##1 (state_reg == ST_MOVE && !move_req);
  endsequence
  a_gear_nonzero: assert property (@(posedge mclk) disable iff (!rstn)
    gear_ratio_numerator_reg != 16'h0 && gear_ratio_denominator_reg != 16'h0)
    else $error("gear value zero");
  a_calc_then_go: assert property (@(posedge mclk) disable iff (!rstn)
    (state_reg == ST_CALC && div_valid && run_lvl && active) |=> s_go)
    else $error("scaled move not issued");
  a_abs_target: assert property (@(posedge mclk) disable iff (!rstn)
    (state_reg == ST_CALC && div_valid && run_lvl && active && cfg_abs && !back_reg)
    |=> move_cmd.target == $past(scaled))
    else $error("absolute target wrong");
  a_back_auto_only: assert property (@(posedge mclk) disable iff (!rstn)
    $rose(back_reg) |-> $past(cfg_auto && cfg[CFG_RECIP]))
    else $error("reciprocating outside automatic cycling");
  a_unsup_no_move: assert property (@(posedge mclk) disable iff (!rstn)
    refuse |=> state_reg != ST_CALC)
    else $error("unsupported mode moved");
  a_mode_gate: assert property (@(posedge mclk) disable iff (!rstn)
    move_req |-> $past(active))
    else $error("move without digital position mode");
  a_first_on_run: assert property (@(posedge mclk) disable iff (!rstn)
    (in_wait && first_go && run_lvl && active && !unsup) |=> state_reg == ST_CALC)
    else $error("first move not started");
  a_postype_write: assert property (@(posedge mclk) disable iff (!rstn)
    (in_wait && pos_go && run_lvl && active && !unsup) |=> state_reg == ST_CALC)
    else $error("target write did not start move");
  a_edge_mode: assert property (@(posedge mclk) disable iff (!rstn)
    (in_wait && !cfg_auto && !cfg[CFG_EN_LEVEL] && !en_rise && !first_go && !pos_go)
    |=> state_reg != ST_CALC)
    else $error("enable level acted in edge mode");
  a_done_level: assert property (@(posedge mclk) disable iff (!rstn)
    (pos_complete && in_wait && run_lvl && active && !move_req && cfg[CFG_DONE_LEVEL])
    |=> (pos_complete || !cfg[CFG_DONE_LEVEL]))
    else $error("level completion dropped");
endmodule : dpc_top

// ### dpc_motion_model.sv
`timescale 1ns/1ns
// ==========================================================
// position loop stand-in: reports each move finished after a delay
module dpc_motion_model #(
  parameter int DELAY = 10
) (
  input wire logic mclk,
  input wire logic rstn,
  input wire logic move_req,
  output logic move_done_pin
);
  import dpc_pkg::*;
  int cnt;
  // count down from each request, then hold done high for four cycles
  always @(posedge mclk) begin
    if (!rstn) begin
      cnt <= 0;
      move_done_pin <= 1'b0;
    end else if (move_req === 1'b1) begin
      cnt <= DELAY + 4;
      move_done_pin <= 1'b0;
    end else if (cnt > 0) begin
      cnt <= cnt - 1;
      move_done_pin <= (cnt <= 4);
    end else begin
      move_done_pin <= 1'b0;
    end
  end
endmodule : dpc_motion_model

// ### dpc_top_tb.sv
`timescale 1ns/1ns
// ==========================================================
// self-checking bench for the positioning block
module dpc_top_tb;
  import dpc_pkg::*;
  localparam int TICK = 4;
  logic mclk = 1'b0;
  logic rstn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic run_pin = 1'b0;
  logic pos_enable_pin = 1'b0;
  logic move_done_pin;
  dpc_move_t move_cmd;
  logic move_req;
  logic pos_complete;
  logic irq;
  int n_errors = 0;
  int num_checks = 0;
  int n_moves = 0;
  int pc_len = 0;
  dpc_move_t moves[$];
  logic [31:0] rd;
  logic err;

  // 10 MHz clock
  always #50 mclk = ~mclk;

  dpc_top #(.HOLD_TICK_CYCLES(TICK)) dpc_top_inst (
    .mclk(mclk), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .run_pin(run_pin), .pos_enable_pin(pos_enable_pin), .move_done_pin(move_done_pin),
    .move_cmd(move_cmd), .move_req(move_req), .pos_complete(pos_complete), .irq(irq)
  );

  dpc_motion_model #(.DELAY(10)) dpc_motion_model_inst (
    .mclk(mclk), .rstn(rstn), .move_req(move_req), .move_done_pin(move_done_pin)
  );

  // log each command and the length of each completion pulse
  always @(posedge mclk) begin
    if (move_req === 1'b1) begin
      moves.push_back(move_cmd);
      n_moves <= n_moves + 1;
      pc_len <= 0;
    end else if (pos_complete === 1'b1) begin
      pc_len <= pc_len + 1;
    end
  end

  task automatic final_report();
    if (n_errors == 0 && num_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask : final_report

  task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected %s: expected %h, seen %h", name, exp, got);
    end
  endtask : chk

  task automatic idle(input int n);
    repeat (n) @(posedge mclk);
  endtask : idle

  // one apb transfer; answer taken at the edge where pready is high
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge mclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge mclk);
    penable <= 1'b1;
    i = 0;
    // sample pready, read data and error at the rising edge itself
    do begin
      @(posedge mclk);
      i++;
    end while (pready !== 1'b1 && i < 50);
    rd = prdata;
    err = pslverr;
    if (pready !== 1'b1) chk("pready", 32'h1, 32'h0);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    apb(1'b1, a, d);
  endtask : wr

  task automatic rdc(input logic [7:0] a, input logic [31:0] exp, input string name);
    apb(1'b0, a, 32'h0);
    chk(name, exp, rd);
  endtask : rdc

  task automatic run(input logic v);
    @(posedge mclk);
    run_pin <= v;
    idle(4);
  endtask : run

  task automatic enable(input logic v);
    @(posedge mclk);
    pos_enable_pin <= v;
    idle(4);
  endtask : enable

  // bounded wait for the k-th move command
  task automatic wait_moves(input int k);
    for (int i = 0; i < 400 && n_moves < k; i++) @(posedge mclk);
    chk("move count", k, n_moves);
  endtask : wait_moves

  // ==========================================================
  // main sequence
  initial begin
    idle(10);
    rstn <= 1'b1;
    rdc(ADDR_GEAR_NUM, 32'h3e8, "numerator reset");
    rdc(ADDR_GEAR_DEN, 32'h3e8, "denominator reset");
    rdc(ADDR_CFG, 32'h0, "config reset");
    wr(ADDR_GEAR_NUM, 32'h0);
    rdc(ADDR_GEAR_NUM, 32'h3e8, "numerator after zero");
    apb(1'b0, 8'h2c, 32'h0);
    chk("unmapped error", 32'h1, 32'(err));
    wr(ADDR_GEAR_NUM, 32'h3);
    wr(ADDR_GEAR_DEN, 32'h2);
    wr(ADDR_TGT_LO, 32'd100);
    wr(ADDR_TGT_HI, 32'h0);
    // other control mode: run alone starts nothing
    wr(ADDR_CFG, 32'h80);
    run(1'b1);
    idle(100);
    chk("moves in other mode", 0, n_moves);
    run(1'b0);
    // bit 7 clear: first move waits for the enable edge
    wr(ADDR_MODE, {16'h0, MODE_DIGITAL_POS});
    wr(ADDR_CFG, 32'h0);
    run(1'b1);
    idle(100);
    chk("moves before enable", 0, n_moves);
    enable(1'b1);
    wait_moves(1);
    enable(1'b0);
    chk("relative target", 32'd150, moves[0].target);
    chk("forward flag", 32'h0, 32'(moves[0].back));
    idle(30);
    chk("pulse length", 32'h1, pc_len);
    rdc(ADDR_POSITION, 32'd150, "position");
    rdc(ADDR_STATUS, 32'h51, "stale status");
    // interrupt raised, masked, cleared
    rdc(ADDR_IRQ_STS, 32'h1, "done status");
    chk("irq masked", 32'h0, 32'(irq));
    wr(ADDR_IRQ_MASK, 32'h1);
    idle(2);
    chk("irq unmasked", 32'h1, 32'(irq));
    wr(ADDR_IRQ_STS, 32'h1);
    idle(2);
    chk("irq cleared", 32'h0, 32'(irq));
    rdc(ADDR_IRQ_STS, 32'h0, "status cleared");
    // first move on the run command, level completion output
    run(1'b0);
    wr(ADDR_TGT_LO, 32'h2);
    wr(ADDR_TGT_HI, 32'h1);
    wr(ADDR_CFG, 32'hc0);
    run(1'b1);
    wait_moves(2);
    chk("relative sum", 32'd98457, moves[1].target);
    idle(40);
    chk("level completion", 32'h1, 32'(pos_complete));
    // absolute, reserved bits set, enable by level, timed completion
    run(1'b0);
    wr(ADDR_HOLD, 32'h2);
    wr(ADDR_TGT_LO, 32'hfff6);
    wr(ADDR_TGT_HI, 32'hffff);
    wr(ADDR_CFG, 32'h131);
    run(1'b1);
    enable(1'b1);
    wait_moves(3);
    enable(1'b0);
    chk("absolute target", 32'hfffffff1, moves[2].target);
    idle(40);
    chk("timed pulse length", 2 * TICK, pc_len);
    // position type in terminal mode is refused
    wr(ADDR_CFG, 32'h8);
    wr(ADDR_IRQ_MASK, 32'h2);
    enable(1'b1);
    idle(80);
    chk("refused move", 32'h3, n_moves);
    rdc(ADDR_IRQ_STS, 32'h3, "refused status");
    chk("refused irq", 32'h1, 32'(irq));
    wr(ADDR_IRQ_STS, 32'h3);
    enable(1'b0);
    // automatic reciprocating: forward then back stroke
    run(1'b0);
    wr(ADDR_TGT_LO, 32'd10);
    wr(ADDR_TGT_HI, 32'h0);
    wr(ADDR_CFG, 32'he);
    run(1'b1);
    wait_moves(5);
    run(1'b0);
    chk("forward dest", 32'h0, moves[3].target);
    chk("forward stroke", 32'h0, 32'(moves[3].back));
    chk("back dest", 32'hfffffff1, moves[4].target);
    chk("back stroke", 32'h1, 32'(moves[4].back));
    final_report();
  end

  // watchdog against a hang
  initial begin
    idle(20000);
    n_errors++;
    final_report();
  end
endmodule : dpc_top_tb
